// ===== rtl/servo_slow_stop_control.sv
/*
  Slow-stop controller: object store, stop-trigger selection, deceleration ramp
  with S-shaping, torque offset feed-forward with lag filter, forced position
  mode and alarm-stop timeout. Assumes the host reaches objects through the
  object port, pins are asynchronous and alarm/mode/velocity/torque inputs come
  from logic on mclk.
*/
`timescale 1ns/100ps
module servo_slow_stop_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Object access port
  input wire servo_slow_stop_pkg::obj_req_type objReq,
  output servo_slow_stop_pkg::obj_rsp_type objRsp,
  // Pins
  input wire logic travelLimitIn,
  input wire logic servoOnIn,
  input wire logic mainPowerOkIn,
  // Drive state inputs
  input wire logic [1:0] overtravelInhibitSelect,
  input wire servo_slow_stop_pkg::ctrl_mode_type controlModeIn,
  input wire logic alarmEstop,
  input wire logic alarmNoEstop,
  input wire logic alarmClear,
  input wire logic signed [15:0] actualVelocity,
  input wire logic signed [15:0] velocityCmdIn,
  input wire logic signed [15:0] torqueCmdIn,
  // Drive outputs
  output logic signed [15:0] velocityCmdOut,
  output logic signed [15:0] torqueCmdOut,
  output servo_slow_stop_pkg::ctrl_mode_type modeOut,
  output logic servoEnergize,
  output logic slowStopActive,
  output logic alarmState,
  output logic estopTimeoutAlarm
);
  import servo_slow_stop_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // One lag step of y toward x; never stalls short of x on a small difference
  function automatic logic signed [15:0] lagStep(input logic signed [15:0] y,
                                                 input logic signed [15:0] x,
                                                 input logic [15:0] tc);
    logic signed [16:0] diff;
    logic [16:0] mag;
    logic [16:0] stp;
    diff = {x[15], x} - {y[15], y};
    mag = diff[16] ? 17'(-diff) : 17'(diff);
    stp = (tc == 16'h0000) ? mag : mag / {1'b0, tc};
    if (stp == 17'h00000 && mag != 17'h00000)
      stp = 17'h00001;
    return diff[16] ? $signed(16'(y - 16'(stp))) : $signed(16'(y + 16'(stp)));
  endfunction

  // Saturating signed add, keeps the torque command from wrapping
  function automatic logic signed [15:0] satAdd(input logic signed [15:0] a,
                                                input logic signed [15:0] b);
    logic signed [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s[16] != s[15])
      return s[16] ? 16'sh8000 : 16'sh7FFF;
    return s[15:0];
  endfunction

  function automatic logic [15:0] absVal(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] filtTime, tqOffset, otSeq, soSeq, poSeq, alSeq;
    logic [15:0] decelTime, sTime, flags, tmo;
    logic [2:0] meta, sync;
    logic [6:0] usCnt;
    logic [3:0] tenUsCnt;
    logic [9:0] msUsCnt;
    logic [13:0] rateCnt;
    logic [10:0] msElapsed;
    stop_state_type st;
    cause_type cause;
    logic signed [15:0] rampV, sOut, ffFilt, velOut, tqOut;
    ctrl_mode_type mode;
    logic energize, alarm, tmoAlarm, active;
    obj_rsp_type rsp;
  } state_type;

  state_type q, d;
  logic usTick, filtTick, msTick, slowEn, travel, servoOn, powerOk;
  logic otHit, soHit, poHit, alHit, eligible, srvOffEdge;
  logic [15:0] wlim;

  assign usTick = (q.usCnt == 7'(US_CYCLES - 1));
  assign filtTick = usTick && (q.tenUsCnt == 4'(FILT_UNIT_US - 1));
  assign msTick = usTick && (q.msUsCnt == 10'(MS_US - 1));
  assign slowEn = q.flags[FLAG_SLOW_STOP_BIT];
  assign travel = q.sync[2];
  assign servoOn = q.sync[1];
  assign powerOk = q.sync[0];
  assign srvOffEdge = q.energize && !servoOn;
  // Trigger qualifiers per sequence selector
  assign otHit = (overtravelInhibitSelect == 2'b00) && travel && (q.otSeq == OT_ESTOP_CODE);
  assign soHit = srvOffEdge && (q.soSeq >= SO_ESTOP_MIN);
  assign poHit = !powerOk && q.energize && (q.poSeq >= PO_ESTOP_MIN);
  assign alHit = alarmEstop && (q.alSeq >= AL_ESTOP_MIN);
  assign eligible = slowEn && q.energize && (controlModeIn != CM_OTHER);

  // Range limit of the addressed object; out-of-range writes are refused
  always_comb
  begin
    unique case (objReq.index)
      IDX_TQ_FILT: wlim = FILT_MAX;
      IDX_OT_SEQ: wlim = OT_SEQ_MAX;
      IDX_SO_SEQ: wlim = SO_SEQ_MAX;
      IDX_PO_SEQ: wlim = PO_SEQ_MAX;
      IDX_AL_SEQ: wlim = AL_SEQ_MAX;
      IDX_DECEL: wlim = DECEL_MAX;
      IDX_SCURVE: wlim = SCURVE_MAX;
      IDX_TMO: wlim = TMO_MAX;
      default: wlim = 16'hFFFF;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.meta = {travelLimitIn, servoOnIn, mainPowerOkIn};
    d.sync = q.meta;
    d.usCnt = usTick ? 7'h00 : 7'(q.usCnt + 7'h01);
    if (usTick)
    begin
      d.tenUsCnt = (q.tenUsCnt == 4'(FILT_UNIT_US - 1)) ? 4'h0 : 4'(q.tenUsCnt + 4'h1);
      d.msUsCnt = (q.msUsCnt == 10'(MS_US - 1)) ? 10'h000 : 10'(q.msUsCnt + 10'h001);
    end
    // Object access: ack one cycle after the request
    d.rsp.ack = objReq.wr || objReq.rd;
    d.rsp.err = 1'b0;
    d.rsp.data = 16'h0000;
    if (objReq.wr || objReq.rd)
    begin
      unique case (objReq.index)
        IDX_TQ_FILT: d.rsp.data = q.filtTime;
        IDX_TQ_OFS: d.rsp.data = q.tqOffset;
        IDX_OT_SEQ: d.rsp.data = q.otSeq;
        IDX_SO_SEQ: d.rsp.data = q.soSeq;
        IDX_PO_SEQ: d.rsp.data = q.poSeq;
        IDX_AL_SEQ: d.rsp.data = q.alSeq;
        IDX_DECEL: d.rsp.data = q.decelTime;
        IDX_SCURVE: d.rsp.data = q.sTime;
        IDX_FLAGS: d.rsp.data = q.flags;
        IDX_TMO: d.rsp.data = q.tmo;
        default: d.rsp.err = 1'b1;
      endcase
      if (objReq.wr && !d.rsp.err && objReq.index != IDX_TQ_OFS
          && objReq.index != IDX_FLAGS && objReq.data > wlim)
        d.rsp.err = 1'b1;
      if (objReq.wr && !d.rsp.err)
      begin
        unique case (objReq.index)
          IDX_TQ_FILT: d.filtTime = objReq.data;
          IDX_TQ_OFS: d.tqOffset = objReq.data;
          IDX_OT_SEQ: d.otSeq = objReq.data;
          IDX_SO_SEQ: d.soSeq = objReq.data;
          IDX_PO_SEQ: d.poSeq = objReq.data;
          IDX_AL_SEQ: d.alSeq = objReq.data;
          IDX_DECEL: d.decelTime = objReq.data;
          IDX_SCURVE: d.sTime = objReq.data;
          IDX_FLAGS: d.flags = objReq.data;
          default: d.tmo = objReq.data;
        endcase
        d.rsp.data = objReq.data;
      end
    end
    // Torque offset lag filter on a 10 us tick
    if (filtTick)
      d.ffFilt = lagStep(q.ffFilt, $signed(q.tqOffset), q.filtTime);
    // Stop sequencer
    unique case (q.st)
      ST_IDLE:
      begin
        d.energize = servoOn && powerOk;
        if (alarmNoEstop || (alHit && q.tmo == 16'h0000))
        begin
          d.st = ST_FAULT;
          d.alarm = 1'b1;
          d.energize = 1'b0;
        end
        else if (eligible && (alHit || otHit || soHit || poHit))
        begin
          d.st = ST_DECEL;
          d.cause = alHit ? CA_ALM : otHit ? CA_OT : soHit ? CA_SOFF : CA_PWR;
          d.energize = 1'b1;
          d.rampV = actualVelocity;
          d.sOut = actualVelocity;
          d.rateCnt = 14'h0000;
          d.msElapsed = 11'h000;
          // Restart the dividers so the stop time is counted from entry, never early
          d.usCnt = 7'h00;
          d.msUsCnt = 10'h000;
        end
        else if (alHit)
        begin
          d.st = ST_FAULT;
          d.alarm = 1'b1;
          d.energize = 1'b0;
        end
      end
      ST_DECEL:
      begin
        // Linear ramp: one r/min step per decelTime microseconds
        if (q.decelTime == 16'h0000)
          d.rampV = 16'sh0000;
        else if (usTick && q.rampV != 16'sh0000)
        begin
          if (q.rateCnt >= 14'(q.decelTime - 16'h0001))
          begin
            d.rateCnt = 14'h0000;
            d.rampV = q.rampV[15] ? 16'(q.rampV + 16'sh0001) : 16'(q.rampV - 16'sh0001);
          end
          else
            d.rateCnt = 14'(q.rateCnt + 14'h0001);
        end
        // S-shaping trails the ramp by a lag of sTime ms
        if (q.sTime == 16'h0000)
          d.sOut = d.rampV;
        else if (msTick)
          d.sOut = lagStep(q.sOut, q.rampV, q.sTime);
        if (msTick && q.msElapsed != 11'h7FF)
          d.msElapsed = 11'(q.msElapsed + 11'h001);
        if (alarmNoEstop)
        begin
          d.st = ST_FAULT;
          d.alarm = 1'b1;
          d.energize = 1'b0;
        end
        else if (q.cause == CA_ALM && {5'h00, q.msElapsed} >= q.tmo)
        begin
          d.st = ST_FAULT;
          d.alarm = 1'b1;
          d.tmoAlarm = 1'b1;
          d.energize = 1'b0;
        end
        else if (q.sOut == 16'sh0000 && absVal(actualVelocity) <= STOP_VEL_RPM)
        begin
          unique case (q.cause)
            CA_OT: d.st = ST_HELD;
            CA_ALM:
            begin
              d.st = ST_FAULT;
              d.alarm = 1'b1;
            end
            default: d.st = ST_IDLE;
          endcase
          d.energize = (q.cause == CA_OT);
        end
      end
      ST_HELD:
      begin
        // Held at rest, energized, until the travel limit releases, servo-on drops or an alarm faults
        if (alarmNoEstop || alarmEstop)
        begin
          d.st = ST_FAULT;
          d.alarm = 1'b1;
          d.energize = 1'b0;
        end
        else if (!travel || !servoOn)
        begin
          d.st = ST_IDLE;
          d.energize = servoOn && powerOk;
        end
      end
      ST_FAULT:
      begin
        d.energize = 1'b0;
        if (alarmClear && !alarmEstop && !alarmNoEstop)
        begin
          d.st = ST_IDLE;
          d.alarm = 1'b0;
          d.tmoAlarm = 1'b0;
        end
      end
    endcase
    if (d.st != ST_DECEL && d.st != ST_HELD)
      d.cause = CA_NONE;
    // Drive outputs follow the next state so they change with it
    d.mode = (d.st == ST_DECEL || d.st == ST_HELD) ? CM_POS : controlModeIn;
    d.active = (d.st == ST_DECEL);
    d.velOut = (d.st == ST_DECEL) ? d.sOut : (d.st == ST_HELD) ? 16'sh0000 : velocityCmdIn;
    d.tqOut = (d.st == ST_DECEL || d.st == ST_HELD) ? torqueCmdIn
            : satAdd(torqueCmdIn, q.ffFilt);
  end

  // ****************************************
  // Register
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cause <= CA_NONE;
      q.mode <= CM_POS;
    end
    else
      q <= d;
  end

  assign objRsp = q.rsp;
  assign velocityCmdOut = q.velOut;
  assign torqueCmdOut = q.tqOut;
  assign modeOut = q.mode;
  assign servoEnergize = q.energize;
  assign slowStopActive = q.active;
  assign alarmState = q.alarm;
  assign estopTimeoutAlarm = q.tmoAlarm;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_decel_ends;
    q.st == ST_DECEL ##1 (q.st == ST_HELD || q.st == ST_IDLE);
  endsequence
  property p_ff_zero;
    q.st == ST_DECEL |=> q.st != ST_DECEL || torqueCmdOut == $past(torqueCmdIn);
  endproperty
  a_ff_zero: assert property (p_ff_zero) else $error("feed-forward not zero in stop");
  property p_ff_add;
    q.st == ST_IDLE ##1 q.st == ST_IDLE |-> torqueCmdOut == satAdd($past(torqueCmdIn), $past(q.ffFilt));
  endproperty
  a_ff_add: assert property (p_ff_add) else $error("torque offset not added");
  property p_pos_mode;
    q.st == ST_DECEL |-> modeOut == CM_POS && servoEnergize;
  endproperty
  a_pos_mode: assert property (p_pos_mode) else $error("not position mode in stop");
  property p_tmo_zero;
    q.st == ST_IDLE && alarmEstop && q.alSeq >= AL_ESTOP_MIN && q.tmo == 16'h0000
      |=> q.st == ST_FAULT && alarmState && !servoEnergize;
  endproperty
  a_tmo_zero: assert property (p_tmo_zero) else $error("zero timeout did not alarm");
  property p_disabled;
    q.st == ST_IDLE && !slowEn |=> q.st != ST_DECEL;
  endproperty
  a_disabled: assert property (p_disabled) else $error("slow stop while disabled");
  property p_done_vel;
    s_decel_ends |-> absVal($past(actualVelocity)) <= STOP_VEL_RPM;
  endproperty
  a_done_vel: assert property (p_done_vel) else $error("stop judged above rest speed");
  property p_tmo_only_alarm;
    q.st == ST_DECEL && q.cause != CA_ALM |=> !estopTimeoutAlarm;
  endproperty
  a_tmo_only_alarm: assert property (p_tmo_only_alarm) else $error("timeout on wrong sequence");
  property p_eligible;
    $rose(q.st == ST_DECEL) |-> $past(controlModeIn) != CM_OTHER && $past(q.energize);
  endproperty
  a_eligible: assert property (p_eligible) else $error("slow stop when not eligible");
  property p_ramp_down;
    q.st == ST_DECEL ##1 q.st == ST_DECEL |-> absVal(q.rampV) <= absVal($past(q.rampV));
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("ramp moved away from zero");
  property p_tmo_fires;
    q.st == ST_DECEL && q.cause == CA_ALM && !alarmNoEstop && {5'h00, q.msElapsed} >= q.tmo
      |=> estopTimeoutAlarm && q.st == ST_FAULT;
  endproperty
  a_tmo_fires: assert property (p_tmo_fires) else $error("alarm stop timeout missed");
endmodule // servo_slow_stop_control

// ===== include/servo_slow_stop_pkg.sv
/*
  Constants, object indexes, enumerations and carrier structs for the slow-stop
  controller. Assumes a 100 MHz single clock and a fieldbus object access port
  that delivers one index and one 16-bit word per request.
*/
package servo_slow_stop_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int FILT_UNIT_US = 10;
  localparam int MS_US = 1000;
  localparam logic [15:0] STOP_VEL_RPM = 16'h001E;

  // ****************************************
  // Object indexes
  // ****************************************
  localparam logic [15:0] IDX_TQ_FILT = 16'h37B3;
  localparam logic [15:0] IDX_TQ_OFS = 16'h60B2;
  localparam logic [15:0] IDX_OT_SEQ = 16'h2505;
  localparam logic [15:0] IDX_SO_SEQ = 16'h2506;
  localparam logic [15:0] IDX_PO_SEQ = 16'h2507;
  localparam logic [15:0] IDX_AL_SEQ = 16'h2510;
  localparam logic [15:0] IDX_DECEL = 16'h2556;
  localparam logic [15:0] IDX_SCURVE = 16'h2557;
  localparam logic [15:0] IDX_FLAGS = 16'h2610;
  localparam logic [15:0] IDX_TMO = 16'h2614;

  // ****************************************
  // Fields, ranges and reset values
  // ****************************************
  localparam int FLAG_SLOW_STOP_BIT = 15;
  localparam int FLAG_FALL_PREV_BIT = 10;
  localparam logic [15:0] FILT_MAX = 16'h1900;
  localparam logic [15:0] DECEL_MAX = 16'h2710;
  localparam logic [15:0] SCURVE_MAX = 16'h03E8;
  localparam logic [15:0] TMO_MAX = 16'h03E8;
  localparam logic [15:0] OT_SEQ_MAX = 16'h0002;
  localparam logic [15:0] SO_SEQ_MAX = 16'h0009;
  localparam logic [15:0] PO_SEQ_MAX = 16'h0009;
  localparam logic [15:0] AL_SEQ_MAX = 16'h0007;
  localparam logic [15:0] OT_ESTOP_CODE = 16'h0002;
  localparam logic [15:0] SO_ESTOP_MIN = 16'h0008;
  localparam logic [15:0] PO_ESTOP_MIN = 16'h0008;
  localparam logic [15:0] AL_ESTOP_MIN = 16'h0004;
  localparam logic [15:0] PARAM_RESET = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {CM_POS = 2'b00, CM_VEL = 2'b01, CM_TRQ = 2'b10,
                            CM_OTHER = 2'b11} ctrl_mode_type;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_DECEL = 2'b01, ST_HELD = 2'b10,
                            ST_FAULT = 2'b11} stop_state_type;
  typedef enum logic [2:0] {CA_NONE = 3'b000, CA_OT = 3'b001, CA_SOFF = 3'b010,
                            CA_PWR = 3'b011, CA_ALM = 3'b100} cause_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [15:0] data;
  } obj_req_type;
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] data;
  } obj_rsp_type;
endpackage

// ===== sim/servo_host_model.sv
/*
  Host motion controller model: issues object reads and writes over the
  object port. Assumes the controller answers one cycle after a request.
*/
`timescale 1ns/100ps
module servo_host_model (
  // Clock
  input wire logic mclk,
  // Object port
  output servo_slow_stop_pkg::obj_req_type objReq,
  input wire servo_slow_stop_pkg::obj_rsp_type objRsp
);
  import servo_slow_stop_pkg::*;

  // Idle bus at time zero
  initial objReq = '0;

  // One request held over its sampling edge, answer taken 1 ns after that same edge
  task automatic access(input logic wrNotRd, input logic [15:0] idx,
                        input logic [15:0] dat, output logic [17:0] rsp);
    @(posedge mclk);
    #1;
    objReq = {wrNotRd, ~wrNotRd, idx, dat};
    @(posedge mclk);
    #1;
    rsp = {objRsp.ack, objRsp.err, objRsp.data};
    // Stale data is not left on the lines once the request is gone
    objReq = {2'b00, ~idx, ~dat};
  endtask

  // Slow-stop setup: semi-closed drive, so the enable bit may be set
  task automatic configure(input logic [15:0] decel, input logic [15:0] tmo);
    logic [17:0] rsp;
    access(1'b1, IDX_FLAGS, 16'h8400, rsp);
    access(1'b1, IDX_OT_SEQ, 16'h0002, rsp);
    access(1'b1, IDX_SO_SEQ, 16'h0008, rsp);
    access(1'b1, IDX_PO_SEQ, 16'h0008, rsp);
    access(1'b1, IDX_AL_SEQ, 16'h0004, rsp);
    access(1'b1, IDX_DECEL, decel, rsp);
    access(1'b1, IDX_SCURVE, 16'h0000, rsp);
    // Timeout kept long against the deceleration time, since velocity lags
    access(1'b1, IDX_TMO, tmo, rsp);
  endtask
endmodule  // servo_host_model

// ===== sim/servo_slow_stop_control_test.sv
/*
  Self-checking testbench for the slow-stop controller. Assumes the host
  model drives the object port and the bench drives pins and drive state.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED at %0t got %h expected %h", $time, (g), (e)); end end
module servo_slow_stop_control_test;
  import servo_slow_stop_pkg::*;
  localparam logic [15:0] REG_IDX [8] = '{IDX_TQ_FILT, IDX_OT_SEQ, IDX_SO_SEQ,
    IDX_PO_SEQ, IDX_AL_SEQ, IDX_DECEL, IDX_SCURVE, IDX_TMO};
  localparam logic [15:0] REG_MAX [8] = '{FILT_MAX, OT_SEQ_MAX, SO_SEQ_MAX,
    PO_SEQ_MAX, AL_SEQ_MAX, DECEL_MAX, SCURVE_MAX, TMO_MAX};
  logic mclk, sys_rst, travelLimitIn, servoOnIn, mainPowerOkIn;
  logic [1:0] overtravelInhibitSelect;
  ctrl_mode_type controlModeIn, modeOut;
  logic alarmEstop, alarmNoEstop, alarmClear;
  logic signed [15:0] actualVelocity, velocityCmdIn, torqueCmdIn;
  logic signed [15:0] velocityCmdOut, torqueCmdOut;
  logic servoEnergize, slowStopActive, alarmState, estopTimeoutAlarm;
  logic [2:0] stat;
  obj_req_type objReq;
  obj_rsp_type objRsp;
  int fails = 0;
  int nChecks = 0;
  assign stat = {servoEnergize, alarmState, slowStopActive};

  // ****************************************
  // Design and host model
  // ****************************************
  servo_slow_stop_control i_servo_slow_stop_control (.mclk(mclk), .sys_rst(sys_rst),
    .objReq(objReq), .objRsp(objRsp), .travelLimitIn(travelLimitIn),
    .servoOnIn(servoOnIn), .mainPowerOkIn(mainPowerOkIn),
    .overtravelInhibitSelect(overtravelInhibitSelect), .controlModeIn(controlModeIn),
    .alarmEstop(alarmEstop), .alarmNoEstop(alarmNoEstop), .alarmClear(alarmClear),
    .actualVelocity(actualVelocity), .velocityCmdIn(velocityCmdIn),
    .torqueCmdIn(torqueCmdIn), .velocityCmdOut(velocityCmdOut),
    .torqueCmdOut(torqueCmdOut), .modeOut(modeOut), .servoEnergize(servoEnergize),
    .slowStopActive(slowStopActive), .alarmState(alarmState),
    .estopTimeoutAlarm(estopTimeoutAlarm));
  servo_host_model i_servo_host_model (.mclk(mclk), .objReq(objReq), .objRsp(objRsp));

  // ****************************************
  // Tasks
  // ****************************************
  // Inputs change 1 ns after the edge so no race with the design's flops
  task automatic tick(input int n = 1);
    repeat (n) begin @(posedge mclk); #1; end
  endtask
  task automatic waitOn(input int sel, input logic v, input int n);
    for (int k = 0; k < n && stat[sel] !== v; k++) tick();
  endtask
  task automatic wrObj(input logic [15:0] idx, input logic [15:0] dat, input logic expErr);
    logic [17:0] rsp;
    i_servo_host_model.access(1'b1, idx, dat, rsp);
    `CHK(rsp[17:16], {1'b1, expErr})
  endtask
  task automatic rdObj(input logic [15:0] idx, input logic [15:0] expVal);
    logic [17:0] rsp;
    i_servo_host_model.access(1'b0, idx, 16'h0000, rsp);
    `CHK(rsp, {2'b10, expVal})
  endtask
  // Rest state with servo on; waits for the drive to energize
  task automatic arm();
    {alarmEstop, travelLimitIn, servoOnIn, mainPowerOkIn} = 4'b0011;
    // Let the released pins pass the synchroniser, so a held stop has ended
    tick(3);
    waitOn(2, 1'b1, 20);
    `CHK(servoEnergize, 1'b1)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Clock, 100 MHz
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Watchdog against a hang; the 1 ms stop timeout alone needs 100000 cycles
  initial
  begin
    #1500000;
    fails++;
    give_verdict();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    {sys_rst, travelLimitIn, servoOnIn, mainPowerOkIn} = 4'b1000;
    overtravelInhibitSelect = 2'b00;
    controlModeIn = CM_VEL;
    {alarmEstop, alarmNoEstop, alarmClear} = 3'b000;
    actualVelocity = 16'sh0032;
    velocityCmdIn = 16'sh0032;
    torqueCmdIn = 16'sh0100;
    repeat (10) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    tick();
    // Object store: reset value, top of range, one above, read back
    for (int i = 0; i < 8; i++)
    begin
      rdObj(REG_IDX[i], PARAM_RESET);
      wrObj(REG_IDX[i], REG_MAX[i], 1'b0);
      wrObj(REG_IDX[i], REG_MAX[i] + 16'h0001, 1'b1);
      rdObj(REG_IDX[i], REG_MAX[i]);
    end
    rdObj(IDX_FLAGS, PARAM_RESET);
    wrObj(IDX_FLAGS, 16'hFFFF, 1'b0);
    wrObj(IDX_TQ_OFS, 16'h8000, 1'b0);
    wrObj(16'h1234, 16'h0001, 1'b1);
    $display("test objects done");
    // Feed-forward without lag, then with the slowest filter
    wrObj(IDX_TQ_FILT, 16'h0000, 1'b0);
    wrObj(IDX_TQ_OFS, 16'h0010, 1'b0);
    for (int k = 0; k < 3000 && torqueCmdOut !== 16'sh0110; k++) tick();
    `CHK(torqueCmdOut, 16'sh0110)
    `CHK(velocityCmdOut, 16'sh0032)
    wrObj(IDX_TQ_FILT, FILT_MAX, 1'b0);
    wrObj(IDX_TQ_OFS, 16'h1000, 1'b0);
    tick(1500);
    `CHK((torqueCmdOut > 16'sh0110) && (torqueCmdOut < 16'sh1100), 1'b1)
    wrObj(IDX_TQ_FILT, 16'h0000, 1'b0);
    wrObj(IDX_TQ_OFS, 16'h0010, 1'b0);
    $display("test feedforward done");
    // Alarm stop: forced position mode, no feed-forward, ramp, stop on actual speed
    i_servo_host_model.configure(16'h0001, 16'h03E8);
    arm();
    alarmEstop = 1'b1;
    waitOn(0, 1'b1, 8);
    `CHK(slowStopActive, 1'b1)
    `CHK(modeOut, CM_POS)
    `CHK(torqueCmdOut, 16'sh0100)
    tick(2500);
    `CHK((velocityCmdOut > 16'sh0000) && (velocityCmdOut < 16'sh0032), 1'b1)
    tick(3500);
    `CHK(velocityCmdOut, 16'sh0000)
    `CHK(stat, 3'b101)
    actualVelocity = 16'sh0000;
    waitOn(1, 1'b1, 20);
    `CHK({alarmState, estopTimeoutAlarm}, 2'b10)
    alarmEstop = 1'b0;
    alarmClear = 1'b1;
    tick();
    alarmClear = 1'b0;
    tick(2);
    `CHK(alarmState, 1'b0)
    $display("test alarm stop done");
    // Zero timeout: over-travel still ramps, alarm faults at once
    wrObj(IDX_TMO, 16'h0000, 1'b0);
    actualVelocity = 16'sh0014;
    arm();
    travelLimitIn = 1'b1;
    waitOn(0, 1'b1, 8);
    `CHK(stat, 3'b101)
    waitOn(0, 1'b0, 3000);
    `CHK(stat, 3'b100)
    `CHK(velocityCmdOut, 16'sh0000)
    travelLimitIn = 1'b0;
    arm();
    alarmEstop = 1'b1;
    waitOn(1, 1'b1, 8);
    `CHK(stat[1:0], 2'b10)
    alarmEstop = 1'b0;
    alarmClear = 1'b1;
    tick();
    alarmClear = 1'b0;
    overtravelInhibitSelect = 2'b01;
    arm();
    travelLimitIn = 1'b1;
    tick(10);
    `CHK(slowStopActive, 1'b0)
    overtravelInhibitSelect = 2'b00;
    $display("test overtravel done");
    // Power loss in an unsupported mode, then in torque mode
    controlModeIn = CM_OTHER;
    arm();
    mainPowerOkIn = 1'b0;
    tick(10);
    `CHK(slowStopActive, 1'b0)
    controlModeIn = CM_TRQ;
    arm();
    mainPowerOkIn = 1'b0;
    waitOn(0, 1'b1, 8);
    `CHK(modeOut, CM_POS)
    waitOn(0, 1'b0, 3000);
    `CHK(stat, 3'b000)
    $display("test power loss done");
    // Servo-off with slow stop enabled, then disabled
    arm();
    servoOnIn = 1'b0;
    waitOn(0, 1'b1, 8);
    `CHK(slowStopActive, 1'b1)
    waitOn(0, 1'b0, 3000);
    `CHK(stat, 3'b000)
    wrObj(IDX_FLAGS, 16'h0000, 1'b0);
    arm();
    servoOnIn = 1'b0;
    tick(8);
    `CHK(stat, 3'b000)
    $display("test servo off done");
    // Alarm stop that outlasts a 1 ms allowance: timeout alarm, never before it
    i_servo_host_model.configure(16'h0001, 16'h0001);
    actualVelocity = 16'sh0032;
    arm();
    alarmEstop = 1'b1;
    waitOn(0, 1'b1, 8);
    `CHK(slowStopActive, 1'b1)
    tick(99990);
    `CHK({alarmState, estopTimeoutAlarm}, 2'b00)
    waitOn(1, 1'b1, 20);
    `CHK({stat, estopTimeoutAlarm}, 4'b0101)
    $display("test stop timeout done");
    give_verdict();
  end
endmodule  // servo_slow_stop_control_test
